// >>> ppp_defs.vh
// constants for the programmable parallel port
`ifndef PPP_DEFS_VH
`define PPP_DEFS_VH
// ****************************************
// sizes
// ****************************************
`define PPP_NSTATES        256
`define PPP_DESC_WORDS     2048
`define PPP_DESC_AW        11
`define PPP_NCTL           16
`define PPP_NCTL_W32       14
`define PPP_NBUF           32
`define PPP_NBUF_BASIC     4
`define PPP_FIFO_DEPTH     32
`define PPP_DATA_W         32
`define PPP_MAX_IF_MHZ     100
`define PPP_MAX_MBPS       375
// ****************************************
// data width selection
// ****************************************
`define PPP_WSEL_8         2'h0
`define PPP_WSEL_16        2'h1
`define PPP_WSEL_24        2'h2
`define PPP_WSEL_32        2'h3
// ****************************************
// pin modes
// ****************************************
`define PPP_PIN_IN         2'h0
`define PPP_PIN_OUT        2'h1
`define PPP_PIN_BIDIR      2'h2
// ****************************************
// descriptor word 0 fields
// ****************************************
`define PPP_W0_OUT_LSB     0
`define PPP_W0_INT         16
`define PPP_W0_PUSH        17
`define PPP_W0_POP         18
`define PPP_W0_DRIVE       19
`define PPP_W0_BUF_LSB     20
// ****************************************
// descriptor word 2 and word 1 fields
// ****************************************
`define PPP_W2_NXT_A_LSB   0
`define PPP_W2_NXT_B_LSB   8
`define PPP_W1_MASK_LSB    0
`define PPP_W1_VAL_LSB     16
`endif

// >>> ppp_far_model.sv
// far processor model on the parallel port
`timescale 1ns/1ns
module ppp_far_model (
  // clock and bench control
  input  wire logic        CLK,
  input  wire logic        go,
  // port side
  input  wire logic [15:0] CTL_OUT,
  input  wire logic        DQ_OE_N,
  input  wire logic [31:0] DQ_OUT,
  output logic      [15:0] CTL_IN,
  output logic      [31:0] DQ_IN,
  output logic      [4:0]  ADDR_IN,
  output logic      [31:0] got
);
  logic [7:0] n_r;
  initial
  begin
    CTL_IN = 16'h0000;
    DQ_IN = 32'h00000000;
    ADDR_IN = 5'h05;
    got = 32'h00000000;
    n_r = 8'h00;
  end
  // capture read data, then move pins after the edge
  always @(posedge CLK)
  begin
    if (DQ_OE_N === 1'h0)
      got <= DQ_OUT;
    #1;
    n_r = CTL_OUT[3] ? n_r + 8'h01 : 8'h00;
    CTL_IN[0] = (go & CTL_OUT[2]) | (CTL_OUT[3] & (n_r < 8'h28));
    CTL_IN[1] = CTL_OUT[5];
    CTL_IN[15:2] = ~CTL_IN[15:2];
    DQ_IN = {16'hABCD, DQ_IN[15:0] + 16'h0001};
    ADDR_IN = CTL_OUT[3] ? 5'h00 : 5'h05;
  end
endmodule // ppp_far_model

// >>> ppp_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module ppp_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // clock and reset
  input  wire             CLK,
  input  wire             NRST,
  // fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // drain side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            do_wr;
  wire            do_rd;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_r];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge CLK)
  begin
    if (do_wr)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge CLK)
  begin
    if (!NRST)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // ppp_fifo

// >>> ppp_port.v
// descriptor-driven waveform state machine for the parallel host port
`timescale 1ns/1ns
`include "ppp_defs.vh"
// Summary of operation
// - the port works as bus master or bus slave, chosen by a mode input.
// - up to 256 states, each defined by firmware in the loaded descriptor.
// - the data bus width is selectable as 8, 16, 24 or 32 bits.
// - the interface runs at up to 100 MHz and the far party must not run it faster.
// - with a 32-bit bus the port offers 14 control pins.
// - with an 8-bit or 16-bit bus the port offers 16 control pins.
// - every control pin is set up on its own as input, output or bidirectional.
// - state transitions are decided from the sampled control inputs.
// - control outputs take the values set by each transition taken.
// - the state machine can drive the host interrupt output.
// - the descriptor sits in a dedicated 8 KB waveform memory of its own.
// - the port can run a parallel protocol, or a serial one for received data on DQ_IN[0]; DQ_OUT always sends in parallel.
// - in slave fifo use the far party reads and writes up to four buffers.
// - with the extension enabled the far party addresses all 32 buffers.
// - the path from port to internal side sustains up to 375 megabytes per second.
module ppp_port #(
  parameter NBUF  = `PPP_NBUF,
  parameter DEPTH = `PPP_FIFO_DEPTH
) (
  // clock and reset
  input  wire        CLK,
  input  wire        NRST,
  // descriptor load
  input  wire        DESC_WE,
  input  wire [10:0] DESC_ADDR,
  input  wire [31:0] DESC_DATA,
  input  wire        DESC_DONE,
  // configuration
  input  wire        PORT_EN,
  input  wire        MASTER,
  input  wire        SERIAL,
  input  wire [1:0]  WIDTH_SEL,
  input  wire [31:0] CTL_MODE,
  input  wire        EXT_ADDR,
  input  wire [31:0] BUF_DIR,
  // control pins
  input  wire [15:0] CTL_IN,
  output wire [15:0] CTL_OUT,
  output wire [15:0] CTL_OE_N,
  // data pins
  input  wire [31:0] DQ_IN,
  output wire [31:0] DQ_OUT,
  output wire        DQ_OE_N,
  // buffer address pins
  input  wire [4:0]  ADDR_IN,
  output wire [4:0]  ADDR_OUT,
  output wire        ADDR_OE_N,
  // host interrupt and flags
  output wire        INT_N,
  output wire        FLAG_FULL,
  output wire        FLAG_EMPTY,
  // internal side
  input  wire [4:0]  US_BUF,
  input  wire [31:0] US_DATA_IN,
  input  wire        US_VALID_IN,
  output wire        US_READY_OUT,
  output wire [31:0] US_DATA_OUT,
  output wire        US_VALID_OUT,
  input  wire        US_READY_IN,
  // status
  output wire        ACTIVE,
  output wire [7:0]  STATE
);
  // ****************************************
  // helpers
  // ****************************************
  function [31:0] width_mask;
    input [1:0] sel;
    begin
      case (sel)
        `PPP_WSEL_8:  width_mask = 32'h000000FF;
        `PPP_WSEL_16: width_mask = 32'h0000FFFF;
        `PPP_WSEL_24: width_mask = 32'h00FFFFFF;
        default:      width_mask = 32'hFFFFFFFF;
      endcase
    end
  endfunction

  function [5:0] width_bits;
    input [1:0] sel;
    begin
      width_bits = {sel, 3'h0} + 6'h08;
    end
  endfunction

  // ****************************************
  // waveform memory
  // ****************************************
  reg  [31:0] desc_mem [0:`PPP_DESC_WORDS-1];
  reg         loaded_r;
  reg  [7:0]  state_r;
  reg  [7:0]  state_nxt;
  reg         active_r;
  wire [31:0] w0;
  wire [31:0] w1;
  wire [31:0] w2;
  wire [31:0] w0_nxt;

  always @(posedge CLK)
  begin
    if (DESC_WE)
    begin
      desc_mem[DESC_ADDR] <= DESC_DATA;
    end
  end

  assign w0     = desc_mem[{state_r, 3'h0}];
  assign w1     = desc_mem[{state_r, 3'h1}];
  assign w2     = desc_mem[{state_r, 3'h2}];
  assign w0_nxt = desc_mem[{state_nxt, 3'h0}];

  // ****************************************
  // pin availability and modes
  // ****************************************
  wire [15:0] avail;
  wire [15:0] in_cap;
  wire [15:0] ctl_in_eff;
  wire [31:0] dmask;
  reg  [15:0] ctl_out_r;
  reg         drive_r;

  // 14 pins on a 32-bit bus, otherwise 16
  assign avail = (WIDTH_SEL == `PPP_WSEL_32) ? 16'h3FFF : 16'hFFFF;
  assign dmask = width_mask(WIDTH_SEL);

  genvar p;
  generate
    for (p = 0; p < `PPP_NCTL; p = p + 1)
    begin : g_pin
      wire [1:0] md;
      assign md = CTL_MODE[2*p+1:2*p];
      assign in_cap[p] = (md != `PPP_PIN_OUT);
      // output pins drive when active, bidir only in drive states
      assign CTL_OE_N[p] = ~(avail[p] & active_r &
                             ((md == `PPP_PIN_OUT) |
                              ((md == `PPP_PIN_BIDIR) & drive_r)));
    end
  endgenerate

  assign ctl_in_eff = CTL_IN & in_cap & avail;
  assign CTL_OUT    = ctl_out_r & avail;

  // ****************************************
  // buffer selection
  // ****************************************
  wire [4:0]  buf_raw;
  wire [4:0]  port_buf;

  // master takes address from descriptor, slave from pins
  assign buf_raw  = MASTER ? w0[`PPP_W0_BUF_LSB+4:`PPP_W0_BUF_LSB] : ADDR_IN;
  assign port_buf = EXT_ADDR ? buf_raw : {3'h0, buf_raw[1:0]};

  // ****************************************
  // serial assembly
  // ****************************************
  reg  [31:0] ser_sh_r;
  reg  [5:0]  ser_cnt_r;
  wire        ser_last;
  wire [31:0] port_wdata;

  assign ser_last   = (ser_cnt_r == width_bits(WIDTH_SEL) - 6'h01);
  assign port_wdata = SERIAL ? ({ser_sh_r[30:0], DQ_IN[0]} & dmask)
                             : (DQ_IN & dmask);

  // ****************************************
  // buffers
  // ****************************************
  wire              act_push;
  wire              act_pop;
  wire              port_push;
  wire              port_pop;
  wire [NBUF-1:0]   f_in_ready;
  wire [NBUF-1:0]   f_out_valid;
  wire [32*NBUF-1:0] f_out_data;
  wire              sel_in_ready;
  wire              sel_out_valid;

  assign act_push  = active_r & PORT_EN & ~DESC_WE & w0[`PPP_W0_PUSH];
  assign act_pop   = active_r & PORT_EN & ~DESC_WE & w0[`PPP_W0_POP];
  assign port_push = act_push & (~SERIAL | ser_last) & ~BUF_DIR[port_buf];
  assign port_pop  = act_pop & BUF_DIR[port_buf];

  genvar b;
  generate
    for (b = 0; b < NBUF; b = b + 1)
    begin : g_buf
      wire        dir;
      wire [31:0] i_data;
      wire        i_valid;
      wire        o_ready;
      assign dir     = BUF_DIR[b];
      // one word per clock in either direction
      assign i_data  = dir ? US_DATA_IN : port_wdata;
      assign i_valid = dir ? (US_VALID_IN & (US_BUF == b))
                           : (port_push & (port_buf == b));
      assign o_ready = dir ? (port_pop & (port_buf == b))
                           : (US_READY_IN & (US_BUF == b));
      ppp_fifo #(
        .WIDTH (`PPP_DATA_W),
        .DEPTH (DEPTH),
        .AW    (5)
      ) u_fifo (
        .CLK       (CLK),
        .NRST      (NRST),
        .in_data   (i_data),
        .in_valid  (i_valid),
        .in_ready  (f_in_ready[b]),
        .out_data  (f_out_data[32*b+31:32*b]),
        .out_valid (f_out_valid[b]),
        .out_ready (o_ready)
      );
    end
  endgenerate

  assign sel_in_ready  = f_in_ready[port_buf];
  assign sel_out_valid = f_out_valid[port_buf];
  assign US_READY_OUT  = BUF_DIR[US_BUF] & f_in_ready[US_BUF];
  assign US_VALID_OUT  = ~BUF_DIR[US_BUF] & f_out_valid[US_BUF];
  assign US_DATA_OUT   = f_out_data[32*US_BUF +: 32];
  assign FLAG_FULL     = ~f_in_ready[port_buf];
  assign FLAG_EMPTY    = ~f_out_valid[port_buf];

  // ****************************************
  // transition logic
  // ****************************************
  wire stall;
  wire cond_hit;

  assign stall = (port_push & ~sel_in_ready) | (port_pop & ~sel_out_valid);
  assign cond_hit = ((ctl_in_eff & w1[`PPP_W1_MASK_LSB+15:`PPP_W1_MASK_LSB]) ==
                     w1[`PPP_W1_VAL_LSB+15:`PPP_W1_VAL_LSB]);

  always @*
  begin
    state_nxt = state_r;
    if (active_r && !stall)
    begin
      state_nxt = cond_hit ? w2[`PPP_W2_NXT_A_LSB+7:`PPP_W2_NXT_A_LSB]
                           : w2[`PPP_W2_NXT_B_LSB+7:`PPP_W2_NXT_B_LSB];
    end
  end

  // ****************************************
  // state and output registers
  // ****************************************
  reg [31:0] dq_out_r;
  reg        dq_oe_n_r;
  reg        int_n_r;

  always @(posedge CLK)
  begin
    if (!NRST)
    begin
      loaded_r  <= 1'b0;
      active_r  <= 1'b0;
      state_r   <= 8'h00;
      ctl_out_r <= 16'h0000;
      drive_r   <= 1'b0;
      int_n_r   <= 1'b1;
      dq_out_r  <= 32'h00000000;
      dq_oe_n_r <= 1'b1;
      ser_sh_r  <= 32'h00000000;
      ser_cnt_r <= 6'h00;
    end
    else
    begin
      if (DESC_WE)
      begin
        loaded_r <= 1'b0;
      end
      else if (DESC_DONE)
      begin
        loaded_r <= 1'b1;
      end
      if (!active_r)
      begin
        // idle until loaded and enabled
        state_r   <= 8'h00;
        ctl_out_r <= 16'h0000;
        drive_r   <= 1'b0;
        int_n_r   <= 1'b1;
        dq_oe_n_r <= 1'b1;
        ser_cnt_r <= 6'h00;
        if (PORT_EN && loaded_r && !DESC_WE && state_r == 8'h00)
        begin
          active_r  <= 1'b1;
          ctl_out_r <= w0[`PPP_W0_OUT_LSB+15:`PPP_W0_OUT_LSB];
          drive_r   <= w0[`PPP_W0_DRIVE];
          int_n_r   <= ~w0[`PPP_W0_INT];
        end
      end
      else if (!PORT_EN || DESC_WE)
      begin
        active_r  <= 1'b0;
        ctl_out_r <= 16'h0000;
        drive_r   <= 1'b0;
        int_n_r   <= 1'b1;
        dq_oe_n_r <= 1'b1;
      end
      else
      begin
        state_r <= state_nxt;
        if (state_nxt != state_r)
        begin
          ctl_out_r <= w0_nxt[`PPP_W0_OUT_LSB+15:`PPP_W0_OUT_LSB];
          drive_r   <= w0_nxt[`PPP_W0_DRIVE];
          int_n_r   <= ~w0_nxt[`PPP_W0_INT];
        end
        if (act_push && SERIAL && !stall)
        begin
          ser_sh_r  <= {ser_sh_r[30:0], DQ_IN[0]};
          ser_cnt_r <= ser_last ? 6'h00 : ser_cnt_r + 6'h01;
        end
        if (port_pop && sel_out_valid)
        begin
          dq_out_r  <= f_out_data[32*port_buf +: 32] & dmask;
          dq_oe_n_r <= 1'b0;
        end
        else if (!act_pop)
        begin
          dq_oe_n_r <= 1'b1;
        end
      end
    end
  end

  assign DQ_OUT    = dq_out_r;
  assign DQ_OE_N   = dq_oe_n_r;
  assign ADDR_OUT  = port_buf;
  assign ADDR_OE_N = ~(MASTER & active_r);
  assign INT_N     = int_n_r;
  assign ACTIVE    = active_r;
  assign STATE     = state_r;
endmodule // ppp_port

// >>> ppp_port_sva.sv
// assertions on the parallel host port pins
`timescale 1ns/1ns
module ppp_port_sva (
  // clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // configuration
  input wire logic        DESC_WE,
  input wire logic        PORT_EN,
  input wire logic        MASTER,
  input wire logic [1:0]  WIDTH_SEL,
  input wire logic [31:0] CTL_MODE,
  // outputs
  input wire logic [15:0] CTL_OUT,
  input wire logic [15:0] CTL_OE_N,
  input wire logic        ADDR_OE_N,
  input wire logic        INT_N,
  input wire logic        ACTIVE,
  input wire logic [7:0]  STATE
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_off; !PORT_EN ##1 !PORT_EN; endsequence
  sequence s_hold; ACTIVE && $past(ACTIVE) && STATE == $past(STATE); endsequence
  property p_idle; !ACTIVE |-> CTL_OE_N == 16'hFFFF && INT_N; endproperty
  property p_off; s_off |=> STATE == 8'h00; endproperty
  property p_en; !PORT_EN |=> !ACTIVE; endproperty
  property p_desc; DESC_WE |=> !ACTIVE; endproperty
  property p_w32; WIDTH_SEL == 2'h3 |-> CTL_OUT[15:14] == 2'h0 && CTL_OE_N[15:14] == 2'h3;
  endproperty
  property p_pin; CTL_MODE[1:0] == 2'h0 |-> CTL_OE_N[0]; endproperty
  property p_hold; s_hold |-> $stable(CTL_OUT); endproperty
  property p_int; $fell(INT_N) |-> ACTIVE; endproperty
  property p_addr; !ADDR_OE_N == (MASTER && ACTIVE); endproperty
  a_idle: assert property (p_idle) else $error("pins driven while idle");
  a_off: assert property (p_off) else $error("state not back to zero");
  a_en: assert property (p_en) else $error("active after disable");
  a_desc: assert property (p_desc) else $error("active during load");
  a_w32: assert property (p_w32) else $error("upper pins used at 32 bits");
  a_pin: assert property (p_pin) else $error("input pin driven");
  a_hold: assert property (p_hold) else $error("outputs moved on self loop");
  a_int: assert property (p_int) else $error("interrupt while idle");
  a_addr: assert property (p_addr) else $error("address drive wrong for mode");
endmodule // ppp_port_sva
bind ppp_port ppp_port_sva i_sva (
  .CLK(CLK), .NRST(NRST), .DESC_WE(DESC_WE), .PORT_EN(PORT_EN), .MASTER(MASTER),
  .WIDTH_SEL(WIDTH_SEL), .CTL_MODE(CTL_MODE), .CTL_OUT(CTL_OUT), .CTL_OE_N(CTL_OE_N),
  .ADDR_OE_N(ADDR_OE_N), .INT_N(INT_N), .ACTIVE(ACTIVE), .STATE(STATE));

// >>> tb_top.sv
// testbench for the parallel host port
`timescale 1ns/1ns
module tb_top;
  logic        CLK, NRST, DESC_WE, DESC_DONE, PORT_EN, MASTER, SERIAL, EXT_ADDR, go;
  logic [10:0] DESC_ADDR;
  logic [31:0] DESC_DATA, CTL_MODE, BUF_DIR, DQ_IN, DQ_OUT, US_DATA_IN, US_DATA_OUT, got;
  logic [1:0]  WIDTH_SEL;
  logic [15:0] CTL_IN, CTL_OUT, CTL_OE_N;
  logic [4:0]  ADDR_IN, ADDR_OUT, US_BUF;
  logic        DQ_OE_N, ADDR_OE_N, INT_N, FLAG_FULL, FLAG_EMPTY, US_VALID_IN, US_READY_OUT;
  logic        US_VALID_OUT, US_READY_IN, ACTIVE;
  logic [7:0]  STATE;
  int          n_fail, checks;
  ppp_port i_dut (
    .CLK(CLK), .NRST(NRST), .DESC_WE(DESC_WE), .DESC_ADDR(DESC_ADDR), .DESC_DATA(DESC_DATA),
    .DESC_DONE(DESC_DONE), .PORT_EN(PORT_EN), .MASTER(MASTER), .SERIAL(SERIAL),
    .WIDTH_SEL(WIDTH_SEL), .CTL_MODE(CTL_MODE), .EXT_ADDR(EXT_ADDR), .BUF_DIR(BUF_DIR),
    .CTL_IN(CTL_IN), .CTL_OUT(CTL_OUT), .CTL_OE_N(CTL_OE_N), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT),
    .DQ_OE_N(DQ_OE_N), .ADDR_IN(ADDR_IN), .ADDR_OUT(ADDR_OUT), .ADDR_OE_N(ADDR_OE_N),
    .INT_N(INT_N), .FLAG_FULL(FLAG_FULL), .FLAG_EMPTY(FLAG_EMPTY), .US_BUF(US_BUF),
    .US_DATA_IN(US_DATA_IN), .US_VALID_IN(US_VALID_IN), .US_READY_OUT(US_READY_OUT),
    .US_DATA_OUT(US_DATA_OUT), .US_VALID_OUT(US_VALID_OUT), .US_READY_IN(US_READY_IN),
    .ACTIVE(ACTIVE), .STATE(STATE));
  ppp_far_model i_far (
    .CLK(CLK), .go(go), .CTL_OUT(CTL_OUT), .DQ_OE_N(DQ_OE_N), .DQ_OUT(DQ_OUT),
    .CTL_IN(CTL_IN), .DQ_IN(DQ_IN), .ADDR_IN(ADDR_IN), .got(got));
  // ****************************************
  // helpers
  // ****************************************
  always #50 CLK = ~CLK;
  task cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wstate(input logic [7:0] s);
    for (int i = 0; i < 300 && STATE !== s; i++)
      cyc(1);
    chk("wait state", s, STATE);
    if (STATE !== s)
      complete_run;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    chk("oe", 16'hFFFF, CTL_OE_N);
    chk("int", 1'h1, INT_N);
    chk("act", 1'h0, ACTIVE);
    chk("empty", 1'h1, FLAG_EMPTY);
  endtask
  task t_load;
    logic [31:0] dw [0:11];
    dw = '{32'h0000C004, 32'h00010001, 32'h00000001, 32'h0003C008, 32'h00000001,
           32'h00000102, 32'h0004C010, 32'h00000000, 32'h00000303, 32'h0000C020,
           32'h00020002, 32'h00000300};
    for (int i = 0; i < 12; i++)
    begin
      DESC_ADDR = 11'((i / 3) * 8 + i % 3);
      DESC_DATA = dw[i];
      DESC_WE = 1'h1;
      cyc(1);
    end
    DESC_WE = 1'h0;
    DESC_DONE = 1'h1;
    cyc(1);
    DESC_DONE = 1'h0;
    US_BUF = 5'h01;
    US_VALID_IN = 1'h1;
    for (int i = 0; i < 20 && US_READY_OUT !== 1'h1; i++)
      @(negedge CLK);
    chk("fill ready", 32'h00000001, US_READY_OUT);
    cyc(1);
    US_VALID_IN = 1'h0;
    PORT_EN = 1'h1;
    cyc(1);
    chk("act", 1'h1, ACTIVE);
    chk("out s0", 16'hC004, CTL_OUT);
    chk("oe s0", 16'h0003, CTL_OE_N);
  endtask
  task t_run;
    logic [31:0] w0;
    int          k;
    go = 1'h1;
    wstate(8'h01);
    go = 1'h0;
    chk("int", 1'h0, INT_N);
    chk("out s1", 16'hC008, CTL_OUT);
    cyc(50);
    chk("full", 1'h1, FLAG_FULL);
    chk("stall", 8'h01, STATE);
    US_BUF = 5'h00;
    US_READY_IN = 1'h1;
    k = 0;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge CLK);
      if (US_VALID_OUT === 1'h1)
      begin
        if (k == 0)
          w0 = US_DATA_OUT;
        if (k < 32)
          chk("word", {16'h0000, w0[15:0] + 16'(k)}, US_DATA_OUT);
        k++;
      end
    end
    cyc(1);
    US_READY_IN = 1'h0;
    chk("depth", 1'h1, k >= 32);
    wstate(8'h00);
    chk("pop", 32'h00001234, got);
  endtask
  task t_stop;
    PORT_EN = 1'h0;
    cyc(2);
    chk("act", 1'h0, ACTIVE);
    chk("state", 8'h00, STATE);
    chk("oe", 16'hFFFF, CTL_OE_N);
  endtask
  task t_w32;
    WIDTH_SEL = 2'h3;
    MASTER = 1'h1;
    PORT_EN = 1'h1;
    cyc(1);
    chk("out w32", 16'h0004, CTL_OUT);
    chk("oe w32", 16'hC003, CTL_OE_N);
    chk("addr oe", 1'h0, ADDR_OE_N);
    chk("addr", 5'h00, ADDR_OUT);
    DESC_ADDR = 11'h000;
    DESC_DATA = 32'h0000C004;
    DESC_WE = 1'h1;
    cyc(1);
    DESC_WE = 1'h0;
    chk("act", 1'h0, ACTIVE);
  endtask
  task t_ser;
    logic [7:0] e;
    int         k;
    cyc(1);
    {WIDTH_SEL, SERIAL, EXT_ADDR} = 4'h3;
    CTL_MODE = 32'h55555552;
    for (int i = 0; i < 3; i++)
    begin
      DESC_ADDR = 11'(i);
      DESC_DATA = (i == 0) ? 32'h005A0000 : 32'h00000000;
      DESC_WE = 1'h1;
      cyc(1);
    end
    DESC_WE = 1'h0;
    DESC_DONE = 1'h1;
    cyc(1);
    DESC_DONE = 1'h0;
    cyc(1);
    chk("addr ext", 32'h00000005, ADDR_OUT);
    chk("oe bidir", 32'h00000002, CTL_OE_N);
    @(negedge CLK);
    e = DQ_IN[0] ? 8'hAA : 8'h55;
    cyc(1);
    US_BUF = 5'h05;
    US_READY_IN = 1'h1;
    k = 0;
    for (int i = 0; i < 40 && k < 2; i++)
    begin
      @(negedge CLK);
      if (US_VALID_OUT === 1'h1)
      begin
        chk("ser byte", {24'h000000, e}, US_DATA_OUT);
        k++;
      end
    end
    chk("ser words", 32'h00000002, k);
    cyc(1);
    {US_READY_IN, PORT_EN, SERIAL} = 3'h0;
    cyc(2);
  endtask
  initial
  begin
    {CLK, NRST, DESC_WE, DESC_DONE, PORT_EN, MASTER, SERIAL, EXT_ADDR, go} = 9'h000;
    {US_VALID_IN, US_READY_IN, US_BUF, DESC_ADDR} = 18'h00000;
    {DESC_DATA, US_DATA_IN} = {32'h00000000, 32'h00001234};
    WIDTH_SEL = 2'h1;
    CTL_MODE = 32'h55555550;
    BUF_DIR = 32'h00000002;
    n_fail = 0;
    checks = 0;
    cyc(10);
    NRST = 1'h1;
    t_reset;
    t_load;
    t_run;
    t_stop;
    t_w32;
    t_ser;
    complete_run;
  end
endmodule // tb_top
